// >>> common/baud_gen_pkg.sv
// Constants, register map and field layout of the fractional baud generator.
// Assumes a 32-bit classic Wishbone slave and one 200 MHz core clock.
package baud_gen_pkg;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] ADDR_BAUD_GEN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FRACTIONAL_RATIO = 8'h04;
  localparam logic [7:0] ADDR_LEGACY_CONFIG    = 8'h08;
  localparam logic [7:0] ADDR_STATUS           = 8'h0C;

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int         ENABLE_BIT           = 7;
  localparam int         RATE_DOUBLE_BIT_POS  = 0;
  localparam int         TX_T2_SELECT_POS     = 1;
  localparam int         RX_T2_SELECT_POS     = 2;
  localparam logic [2:0] DIV_RESET            = 3'h0;
  localparam logic [7:0] RATIO_RESET          = 8'h00;

  // ****************************************************
  // Divider constants
  // ****************************************************
  localparam logic [9:0] RATIO_OFFSET   = 10'h040;
  localparam logic [9:0] ACC_STEP       = 10'h002;
  localparam logic [6:0] MODE0_DIVIDE   = 7'h0C;
  localparam logic [6:0] MODE2_DIVIDE   = 7'h40;
  localparam logic [6:0] MODE2_DOUBLED  = 7'h20;
  localparam logic [6:0] T1_DIVIDE      = 7'h20;
  localparam logic [6:0] T1_DOUBLED     = 7'h10;
  localparam logic [6:0] T2_DIVIDE      = 7'h10;

  // UART operating modes as seen by the rate logic
  typedef enum logic [1:0] {
    MODE_SHIFT   = 2'b00,
    MODE_VAR8    = 2'b01,
    MODE_FIXED9  = 2'b10,
    MODE_VAR9    = 2'b11
  } uart_mode_t;

endpackage

// >>> hw/fractional_baud_generator.sv
// Fractional baud generator with legacy rate selection and Wishbone registers.
// Assumes the UART supplies its mode and the timer overflow pulses, all on sys_clk_i.
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

module fractional_baud_generator
  import baud_gen_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // UART and timer side
  input  wire logic [1:0]  uart_mode_i,
  input  wire logic        timer1_overflow_i,
  input  wire logic        timer2_overflow_i,
  output logic             tx_baud_tick_o,
  output logic             rx_baud_tick_o
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic        baud_gen_enable;
    logic [2:0]  core_clock_divider;
    logic [7:0]  fractional_ratio_value;
    logic        rate_double_bit;
    logic        tx_timer2_select;
    logic        rx_timer2_select;
    logic [6:0]  pre_cnt;
    logic [9:0]  acc;
    logic [6:0]  tx_cnt;
    logic [6:0]  rx_cnt;
    logic [7:0]  tick_count;
    logic [7:0]  tick_gap;
    logic        tx_tick;
    logic        rx_tick;
    logic        ack;
    logic [31:0] dat;
  } state_t;

  state_t st;
  state_t next_st;

  // Legacy counter step: returns {tick, next count}
  function automatic logic [7:0] legacy_step(input logic [6:0] cnt,
                                             input logic       ev,
                                             input logic [6:0] lim);
    logic [6:0] nc;
    nc = cnt;
    legacy_step = {1'b0, cnt};
    if (ev) begin
      nc = cnt + 7'h01;
      if (nc >= lim) begin
        legacy_step = {1'b1, 7'h00};
      end else begin
        legacy_step = {1'b0, nc};
      end
    end
  endfunction

  // ****************************************************
  // Next-state logic
  // ****************************************************
  logic [6:0] pre_mask;
  logic       pre_tick;
  logic [9:0] acc_sum;
  logic [9:0] ratio_total;
  logic       gen_tick;
  logic       tx_ev;
  logic       rx_ev;
  logic [6:0] tx_lim;
  logic [6:0] rx_lim;
  logic [7:0] tx_res;
  logic [7:0] rx_res;
  logic       req;
  logic       wr;

  always_comb begin
    next_st     = st;
    // Prescaler terminal count: divide by 2^field, 1..128
    pre_mask    = 7'((8'h01 << st.core_clock_divider) - 8'h01);
    pre_tick    = (st.pre_cnt & pre_mask) == pre_mask;
    ratio_total = {2'b00, st.fractional_ratio_value} + RATIO_OFFSET;
    // Adding two per prescaled cycle gives the factor 2 in the rate
    acc_sum     = st.acc + ACC_STEP;
    gen_tick    = 1'b0;
    tx_ev       = 1'b0;
    rx_ev       = 1'b0;
    tx_lim      = MODE2_DIVIDE;
    rx_lim      = MODE2_DIVIDE;
    tx_res      = 8'h00;
    rx_res      = 8'h00;

    // sys_clk_i is the PLL core clock, not the crystal
    if (st.baud_gen_enable) begin
      next_st.pre_cnt = pre_tick ? 7'h00 : st.pre_cnt + 7'h01;
      if (pre_tick) begin
        if (acc_sum >= ratio_total) begin
          next_st.acc = acc_sum - ratio_total;
          gen_tick    = 1'b1;
        end else begin
          next_st.acc = acc_sum;
        end
      end
      // Legacy counters parked, doubling and selects disregarded
      next_st.tx_cnt  = 7'h00;
      next_st.rx_cnt  = 7'h00;
      next_st.tx_tick = gen_tick;
      next_st.rx_tick = gen_tick;
    end else begin
      next_st.pre_cnt = 7'h00;
      next_st.acc     = 10'h000;
      unique case (uart_mode_t'(uart_mode_i))
        MODE_SHIFT: begin
          tx_ev  = 1'b1;
          rx_ev  = 1'b1;
          tx_lim = MODE0_DIVIDE;
          rx_lim = MODE0_DIVIDE;
        end
        MODE_FIXED9: begin
          tx_ev  = 1'b1;
          rx_ev  = 1'b1;
          tx_lim = st.rate_double_bit ? MODE2_DOUBLED : MODE2_DIVIDE;
          rx_lim = tx_lim;
        end
        MODE_VAR8, MODE_VAR9: begin
          // Timer 2 select bits route each direction to timer 2
          tx_ev  = st.tx_timer2_select ? timer2_overflow_i : timer1_overflow_i;
          rx_ev  = st.rx_timer2_select ? timer2_overflow_i : timer1_overflow_i;
          tx_lim = st.tx_timer2_select ? T2_DIVIDE
                 : (st.rate_double_bit ? T1_DOUBLED : T1_DIVIDE);
          rx_lim = st.rx_timer2_select ? T2_DIVIDE
                 : (st.rate_double_bit ? T1_DOUBLED : T1_DIVIDE);
        end
      endcase
      tx_res          = legacy_step(st.tx_cnt, tx_ev, tx_lim);
      rx_res          = legacy_step(st.rx_cnt, rx_ev, rx_lim);
      next_st.tx_cnt  = tx_res[6:0];
      next_st.rx_cnt  = rx_res[6:0];
      next_st.tx_tick = tx_res[7];
      next_st.rx_tick = rx_res[7];
    end
    if (next_st.tx_tick) begin
      next_st.tick_count = st.tick_count + 8'h01;
    end
    // Cycles since the last transmit tick, saturating; only the checks read it
    if (st.tx_tick) begin
      next_st.tick_gap = 8'h01;
    end else if (st.tick_gap != 8'hFF) begin
      next_st.tick_gap = st.tick_gap + 8'h01;
    end

    // Wishbone: ack one cycle after request, dropped the cycle after
    req         = wb_cyc_i && wb_stb_i && !st.ack;
    wr          = req && wb_we_i && wb_sel_i[0];
    next_st.ack = req;
    next_st.dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_BAUD_GEN_CONTROL: begin
          next_st.dat[ENABLE_BIT] = st.baud_gen_enable;
          next_st.dat[2:0]        = st.core_clock_divider;
        end
        ADDR_FRACTIONAL_RATIO: next_st.dat[7:0] = st.fractional_ratio_value;
        ADDR_LEGACY_CONFIG: begin
          next_st.dat[RATE_DOUBLE_BIT_POS] = st.rate_double_bit;
          next_st.dat[TX_T2_SELECT_POS]    = st.tx_timer2_select;
          next_st.dat[RX_T2_SELECT_POS]    = st.rx_timer2_select;
        end
        ADDR_STATUS: next_st.dat[7:0] = st.tick_count;
        default: next_st.dat = 32'h0000_0000;
      endcase
    end
    // Writes to unmapped or read-only words are acknowledged and dropped
    if (wr) begin
      unique case (wb_adr_i)
        // Restart the fraction: a smaller total must not strand the accumulator above it
        ADDR_BAUD_GEN_CONTROL: begin
          next_st.baud_gen_enable    = wb_dat_i[ENABLE_BIT];
          next_st.core_clock_divider = wb_dat_i[2:0];
          next_st.acc                = 10'h000;
        end
        ADDR_FRACTIONAL_RATIO: begin
          next_st.fractional_ratio_value = wb_dat_i[7:0];
          next_st.acc                    = 10'h000;
        end
        ADDR_LEGACY_CONFIG: begin
          next_st.rate_double_bit  = wb_dat_i[RATE_DOUBLE_BIT_POS];
          next_st.tx_timer2_select = wb_dat_i[TX_T2_SELECT_POS];
          next_st.rx_timer2_select = wb_dat_i[RX_T2_SELECT_POS];
        end
        default: next_st.dat = next_st.dat;
      endcase
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st                        <= '0;
      st.core_clock_divider     <= DIV_RESET;
      st.fractional_ratio_value <= RATIO_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o       = st.dat;
  assign wb_ack_o       = st.ack;
  assign tx_baud_tick_o = st.tx_tick;
  assign rx_baud_tick_o = st.rx_tick;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_disabled_clears_counters: assert property (
    !st.baud_gen_enable |=> (st.acc == 10'h000) && (st.pre_cnt == 7'h00))
    else $error("generator counters not cleared while disabled");

  a_common_tick: assert property (
    st.baud_gen_enable && $past(st.baud_gen_enable) |-> (tx_baud_tick_o == rx_baud_tick_o))
    else $error("tx and rx ticks differ with generator enabled");

  a_legacy_parked: assert property (
    st.baud_gen_enable |=> (st.tx_cnt == 7'h00) && (st.rx_cnt == 7'h00))
    else $error("legacy counters active while generator enabled");

  a_prescale_by_two: assert property (
    st.baud_gen_enable && $stable(st.baud_gen_enable) && (st.core_clock_divider == 3'h1)
      && (st.pre_cnt == 7'h00) && !wr |=> (st.pre_cnt == 7'h01) ##1 (st.pre_cnt == 7'h00))
    else $error("divide-by-two prescaler sequence wrong");

  a_acc_below_total: assert property (
    st.baud_gen_enable && $stable(st.fractional_ratio_value) && $past(st.baud_gen_enable)
      |-> (st.acc < ratio_total))
    else $error("fractional accumulator exceeded ratio total");

  a_tick_spacing: assert property (
    st.baud_gen_enable && tx_baud_tick_o && $stable(st.fractional_ratio_value)
      |=> !tx_baud_tick_o [*8])
    else $error("generator ticks closer than the minimum ratio allows");

  a_mode2_spacing: assert property (
    !st.baud_gen_enable && (uart_mode_i == MODE_FIXED9) && st.rate_double_bit
      && $stable(uart_mode_i) && tx_baud_tick_o
      |=> !tx_baud_tick_o [*8])
    else $error("mode 2 doubled rate ticks too early");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack held more than one cycle");

  a_enable_write: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && (wb_adr_i == ADDR_BAUD_GEN_CONTROL)
      |=> (st.baud_gen_enable == $past(wb_dat_i[ENABLE_BIT])))
    else $error("enable bit did not follow the control write");

  a_gen_min_gap: assert property (
    st.baud_gen_enable && $past(st.baud_gen_enable) && tx_baud_tick_o
      |-> (st.tick_gap >= 8'(RATIO_OFFSET / ACC_STEP)))
    else $error("generator tick gap below the smallest ratio period");

  a_fraction_restart: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && ((wb_adr_i == ADDR_BAUD_GEN_CONTROL) || (wb_adr_i == ADDR_FRACTIONAL_RATIO))
      |=> (st.acc == 10'h000))
    else $error("accumulator not restarted by a rate setting write");

  a_ratio_write: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && (wb_adr_i == ADDR_FRACTIONAL_RATIO)
      |=> (st.fractional_ratio_value == $past(wb_dat_i[7:0])))
    else $error("fractional ratio did not follow the write");

  a_sel_gates_write: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0] && !wb_ack_o
      |=> $stable(st.baud_gen_enable) && $stable(st.core_clock_divider))
    else $error("write without lane 0 changed the control register");

  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("wishbone request not acknowledged in the next cycle");

  a_ack_needs_req: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("wishbone ack without a request");

  a_idle_data_zero: assert property (
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero outside the ack cycle");

endmodule // fractional_baud_generator

// >>> testbench/uart_link_model.sv
// UART side model: counts transmit bit-rate ticks and makes timer overflow pulses.
// Assumes one clock shared with the generator.
`timescale 1ns/1ps

module uart_link_model (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // Tick from the generator
  input  wire logic tx_baud_tick_i,
  // Timer side
  input  wire logic run_i,
  output logic      timer1_overflow_o,
  output logic      timer2_overflow_o,
  output int        tx_ticks_o
);
  int c1;
  int c2;

  // ****************************************************
  // Overflow pulses, unequal spacing so paths differ
  // ****************************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      c1 <= 0;
      c2 <= 0;
      timer1_overflow_o <= 1'b0;
      timer2_overflow_o <= 1'b0;
      tx_ticks_o <= 0;
    end else begin
      c1 <= (c1 == 2) ? 0 : c1 + 1;
      c2 <= (c2 == 4) ? 0 : c2 + 1;
      timer1_overflow_o <= run_i && (c1 == 2);
      timer2_overflow_o <= run_i && (c2 == 4);
      tx_ticks_o <= tx_ticks_o + int'(tx_baud_tick_i);
    end
  end
endmodule // uart_link_model

// >>> testbench/fractional_baud_generator_test.sv
// Self-checking bench for the fractional baud generator.
// Assumes the link model drives the timer overflow pulses.
`timescale 1ns/1ps

module fractional_baud_generator_test;
  import baud_gen_pkg::*;
  logic        sys_clk_i, reset_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, run;
  logic        timer1_overflow_i, timer2_overflow_i, tx_baud_tick_o, rx_baud_tick_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [1:0]  uart_mode_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          tx_n, errors, num_checks, p, f, r;
  bit   [31:0] seed = 32'h658B1ACD;
  real         a;
  int          lt[7][4] = '{'{0,0,24,24}, '{2,0,128,128}, '{2,1,64,64}, '{1,0,192,192},
                            '{1,1,96,96}, '{3,2,160,192}, '{1,4,192,160}};
  int          rates[2] = '{115200, 230400};

  fractional_baud_generator u_fractional_baud_generator (.sys_clk_i, .reset_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .uart_mode_i,
    .timer1_overflow_i, .timer2_overflow_i, .tx_baud_tick_o, .rx_baud_tick_o);
  uart_link_model u_uart_link_model (.sys_clk_i, .reset_i, .tx_baud_tick_i(tx_baud_tick_o),
    .run_i(run), .timer1_overflow_o(timer1_overflow_i),
    .timer2_overflow_o(timer2_overflow_i), .tx_ticks_o(tx_n));

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] ad, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= s;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 16) begin
      errors++;
      end_sim();
    end
  endtask

  // Cycles spanned by two tick intervals, anchored on a first tick
  task automatic meas(input bit rx, output int cyc);
    int n;
    int k;
    n = 0;
    k = 0;
    cyc = 0;
    while (k < 3 && n < 8000) begin
      @(posedge sys_clk_i);
      n++;
      if (k > 0) cyc++;
      if ((rx ? rx_baud_tick_o : tx_baud_tick_o) === 1'b1) k++;
    end
    if (k < 3) begin
      errors++;
      end_sim();
    end
  endtask

  task automatic both(input int et, input int er);
    meas(1'b0, p);
    chk(p, et);
    meas(1'b1, p);
    chk(p, er);
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    {reset_i, run, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h10;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'h0;
    uart_mode_i = 2'b01;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00, 4'h1);
      chk(q, 32'h00000000);
    end
    wb(1'b1, ADDR_BAUD_GEN_CONTROL, 8'h87, 4'hE);
    wb(1'b1, 8'h10, 8'hFF, 4'h1);
    wb(1'b1, ADDR_STATUS, 8'hFF, 4'h1);
    wb(1'b0, ADDR_STATUS, 8'h00, 4'h1);
    chk(q, 32'h00000000);
    wb(1'b1, ADDR_BAUD_GEN_CONTROL, 8'h7F, 4'h1);
    wb(1'b0, ADDR_BAUD_GEN_CONTROL, 8'h00, 4'h1);
    chk(q, 32'h00000007);
    wb(1'b1, ADDR_LEGACY_CONFIG, 8'h07, 4'h1);
    wb(1'b0, ADDR_LEGACY_CONFIG, 8'h00, 4'h1);
    chk(q, 32'h00000007);
    for (int i = 0; i < 6; i++) begin
      f = int'(rnd() % 3);
      r = int'(rnd() % 256);
      wb(1'b1, ADDR_FRACTIONAL_RATIO, 8'(r), 4'h1);
      wb(1'b0, ADDR_FRACTIONAL_RATIO, 8'h00, 4'h1);
      chk(q, 32'(r));
      wb(1'b1, ADDR_BAUD_GEN_CONTROL, 8'h80 | 8'(f), 4'h1);
      both((2 ** f) * (r + 64), (2 ** f) * (r + 64));
    end
    // Software settings from the 200 MHz core clock
    foreach (rates[i]) begin
      f = 0;
      while (200.0e6 / (32.0 * rates[i]) >= 2.0 ** (f + 1)) f++;
      r = $rtoi(400.0e6 / ((2.0 ** f) * rates[i]) - 63.5);
      wb(1'b1, ADDR_FRACTIONAL_RATIO, 8'(r), 4'h1);
      wb(1'b1, ADDR_BAUD_GEN_CONTROL, 8'h80 | 8'(f), 4'h1);
      both((2 ** f) * (r + 64), (2 ** f) * (r + 64));
      a = 400.0e6 / p;
      chk(32'((a - rates[i]) < 0.008 * rates[i] && (rates[i] - a) < 0.008 * rates[i]), 1);
    end
    wb(1'b1, ADDR_BAUD_GEN_CONTROL, 8'h00, 4'h1);
    run <= 1'b1;
    foreach (lt[i]) begin
      uart_mode_i <= 2'(lt[i][0]);
      wb(1'b1, ADDR_LEGACY_CONFIG, 8'(lt[i][1]), 4'h1);
      both(lt[i][2], lt[i][3]);
    end
    run <= 1'b0;
    uart_mode_i <= 2'b01;
    repeat (8) @(posedge sys_clk_i);
    wb(1'b0, ADDR_STATUS, 8'h00, 4'h1);
    chk(q, 32'(tx_n % 256));
    end_sim();
  end
endmodule // fractional_baud_generator_test
